// ---- src/ccrc_defs.svh ----
// Register offsets, field positions, reset values and setpoint constants
`ifndef CCRC_DEFS_SVH
`define CCRC_DEFS_SVH
`define CCRC_ADDR_CUR        8'h04
`define CCRC_ADDR_THR        8'h05
`define CCRC_FCC_HI          6
`define CCRC_FCC_LO          2
`define CCRC_TWC_HI          1
`define CCRC_TWC_LO          0
`define CCRC_RDIS_BIT        7
`define CCRC_RTH_HI          6
`define CCRC_RTH_LO          5
`define CCRC_FCC_RST         5'h0e
`define CCRC_TWC_RST         2'h2
`define CCRC_RDIS_RST        1'h0
`define CCRC_RTH_RST         2'h3
`define CCRC_FCC_STEP_MA     11'h032
`define CCRC_FCC_RST_MA      11'h2ee
`define CCRC_FCC_1200_CODE   5'h16
`define CCRC_FCC_1200_MA     11'h4b0
`define CCRC_FCC_1300_MA     11'h514
`define CCRC_TWC_MA0         7'h05
`define CCRC_TWC_MA1         7'h0a
`define CCRC_TWC_MA2         7'h14
`define CCRC_TWC_MA3         7'h50
`define CCRC_RTH_MV0         9'h050
`define CCRC_RTH_MV1         9'h08c
`define CCRC_RTH_MV2         9'h0c8
`define CCRC_RTH_MV3         9'h104
`endif

// ---- src/ccrc_pkg.sv ----
// Types shared by the charge current and recharge configuration block
package ccrc_pkg;
  typedef logic [7:0] ccrc_byte_t;
endpackage

// ---- src/ccrc_regs.sv ----
// Charge current and recharge configuration registers with setpoint decode
`timescale 1ns/1ps
`include "ccrc_defs.svh"
module ccrc_regs
  import ccrc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Register access from the serial host interface
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_wr_en,
  input  wire ccrc_byte_t        i_wr_data,
  output ccrc_byte_t             o_rd_data,
  // Codes and setpoints to the analog loops
  output logic [4:0]             o_fast_charge_current_code,
  output logic [1:0]             o_trickle_weak_current_code,
  output logic                   o_recharge_disable,
  output logic [1:0]             o_recharge_threshold_code,
  output logic [10:0]            o_fast_charge_ma,
  output logic [6:0]             o_trickle_weak_ma,
  output logic [8:0]             o_recharge_threshold_mv,
  output logic                   o_recharge_enable
);

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  logic [4:0]  fcc_q, fcc_d;
  logic [1:0]  twc_q, twc_d;
  logic        rdis_q, rdis_d;
  logic [1:0]  rth_q, rth_d;
  ccrc_byte_t  rd_d;
  logic [10:0] fma_d;
  logic [6:0]  tma_d;
  logic [8:0]  rmv_d;

  function automatic logic [10:0] fcc_ma(input logic [4:0] c);
    if (c < `CCRC_FCC_1200_CODE)
      fcc_ma = 11'(({6'h00, c} + 11'h001) * `CCRC_FCC_STEP_MA);
    else if (c == `CCRC_FCC_1200_CODE)
      fcc_ma = `CCRC_FCC_1200_MA;
    else
      fcc_ma = `CCRC_FCC_1300_MA;
  endfunction

  // Exact match on the full address, so a wider bus never aliases onto the registers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input ccrc_byte_t reg_addr);
    addr_hit = (a == ADDR_W'(reg_addr));
  endfunction

  wire logic hit_cur = addr_hit(i_addr, `CCRC_ADDR_CUR);
  wire logic hit_thr = addr_hit(i_addr, `CCRC_ADDR_THR);

  // Read data is built from next values so a write shows in the same read
  always_comb begin
    fcc_d  = fcc_q;
    twc_d  = twc_q;
    rdis_d = rdis_q;
    rth_d  = rth_q;
    if (i_wr_en && hit_cur) begin
      fcc_d = i_wr_data[`CCRC_FCC_HI:`CCRC_FCC_LO];
      twc_d = i_wr_data[`CCRC_TWC_HI:`CCRC_TWC_LO];
    end
    if (i_wr_en && hit_thr) begin
      rdis_d = i_wr_data[`CCRC_RDIS_BIT];
      rth_d  = i_wr_data[`CCRC_RTH_HI:`CCRC_RTH_LO];
    end
    if (hit_cur)
      rd_d = {1'b0, fcc_d, twc_d};
    else if (hit_thr)
      rd_d = {rdis_d, rth_d, 5'h00};
    else
      rd_d = 8'h00;
    fma_d = fcc_ma(fcc_d);
    unique case (twc_d)
      2'h0: tma_d = `CCRC_TWC_MA0;
      2'h1: tma_d = `CCRC_TWC_MA1;
      2'h2: tma_d = `CCRC_TWC_MA2;
      2'h3: tma_d = `CCRC_TWC_MA3;
    endcase
    unique case (rth_d)
      2'h0: rmv_d = `CCRC_RTH_MV0;
      2'h1: rmv_d = `CCRC_RTH_MV1;
      2'h2: rmv_d = `CCRC_RTH_MV2;
      2'h3: rmv_d = `CCRC_RTH_MV3;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fcc_q                   <= `CCRC_FCC_RST;
      twc_q                   <= `CCRC_TWC_RST;
      rdis_q                  <= `CCRC_RDIS_RST;
      rth_q                   <= `CCRC_RTH_RST;
      o_rd_data               <= 8'h00;
      o_fast_charge_ma        <= `CCRC_FCC_RST_MA;
      o_trickle_weak_ma       <= `CCRC_TWC_MA2;
      o_recharge_threshold_mv <= `CCRC_RTH_MV3;
    end else begin
      fcc_q                   <= fcc_d;
      twc_q                   <= twc_d;
      rdis_q                  <= rdis_d;
      rth_q                   <= rth_d;
      o_rd_data               <= rd_d;
      o_fast_charge_ma        <= fma_d;
      o_trickle_weak_ma       <= tma_d;
      o_recharge_threshold_mv <= rmv_d;
    end
  end

  assign o_fast_charge_current_code  = fcc_q;
  assign o_trickle_weak_current_code = twc_q;
  assign o_recharge_disable          = rdis_q;
  assign o_recharge_threshold_code   = rth_q;
  assign o_recharge_enable           = !rdis_q;

  // Checks on stored codes, decoded setpoints and read data
  property p_fcc_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && hit_cur) |=> (fcc_q == $past(i_wr_data[`CCRC_FCC_HI:`CCRC_FCC_LO]));
  endproperty
  a_fcc_write: assert property (p_fcc_write) else $error("fast code not stored");

  property p_twc_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && hit_cur) |=> (twc_q == $past(i_wr_data[`CCRC_TWC_HI:`CCRC_TWC_LO]));
  endproperty
  a_twc_write: assert property (p_twc_write) else $error("trickle code not stored");

  property p_cur_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !(i_wr_en && hit_cur) |=> ($stable(fcc_q) && $stable(twc_q));
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("current register changed without write");

  property p_fcc_ma;
    @(posedge i_clk) disable iff (!i_rst_n)
      ##1 (fcc_q < `CCRC_FCC_1200_CODE) |-> (o_fast_charge_ma == 11'(`CCRC_FCC_STEP_MA * (fcc_q + 1)));
  endproperty
  a_fcc_ma: assert property (p_fcc_ma) else $error("fast current decode wrong");

  property p_fcc_top;
    @(posedge i_clk) disable iff (!i_rst_n)
      ##1 (fcc_q >= `CCRC_FCC_1200_CODE) |->
        (o_fast_charge_ma == ((fcc_q == `CCRC_FCC_1200_CODE) ? `CCRC_FCC_1200_MA : `CCRC_FCC_1300_MA));
  endproperty
  a_fcc_top: assert property (p_fcc_top) else $error("top fast current wrong");

  property p_twc_ma;
    @(posedge i_clk) disable iff (!i_rst_n)
      ##1 1'b1 |-> (o_trickle_weak_ma == ((twc_q == 2'h3) ? `CCRC_TWC_MA3 : 7'(`CCRC_TWC_MA0 << twc_q)));
  endproperty
  a_twc_ma: assert property (p_twc_ma) else $error("trickle decode wrong");

  property p_rdis;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && hit_thr) |=> (o_recharge_enable == !$past(i_wr_data[`CCRC_RDIS_BIT]));
  endproperty
  a_rdis: assert property (p_rdis) else $error("recharge disable not applied");

  property p_rdis_code;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && hit_thr) |=> (rdis_q == $past(i_wr_data[`CCRC_RDIS_BIT]));
  endproperty
  a_rdis_code: assert property (p_rdis_code) else $error("recharge disable bit not stored");

  property p_rth_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && hit_thr) |=> (rth_q == $past(i_wr_data[`CCRC_RTH_HI:`CCRC_RTH_LO]));
  endproperty
  a_rth_write: assert property (p_rth_write) else $error("threshold code not stored");

  property p_thr_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !(i_wr_en && hit_thr) |=> ($stable(rdis_q) && $stable(rth_q));
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold register changed without write");

  property p_rth_mv;
    @(posedge i_clk) disable iff (!i_rst_n)
      ##1 1'b1 |-> (o_recharge_threshold_mv == 9'(`CCRC_RTH_MV0 + (`CCRC_RTH_MV1 - `CCRC_RTH_MV0) * rth_q));
  endproperty
  a_rth_mv: assert property (p_rth_mv) else $error("threshold decode wrong");

  property p_bit7;
    @(posedge i_clk) disable iff (!i_rst_n)
      hit_cur |=> (o_rd_data[7] == 1'b0);
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 not zero");

  property p_cur_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      hit_cur |=> (o_rd_data == {1'b0, fcc_q, twc_q});
  endproperty
  a_cur_read: assert property (p_cur_read) else $error("current register read wrong");

  property p_thr_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      hit_thr |=> (o_rd_data == {rdis_q, rth_q, 5'h00});
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("threshold register read wrong");

  property p_unmapped;
    @(posedge i_clk) disable iff (!i_rst_n)
      !(hit_cur || hit_thr) |=> (o_rd_data == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_reset;
    @(posedge i_clk) $rose(i_rst_n) |->
      (fcc_q == `CCRC_FCC_RST && twc_q == `CCRC_TWC_RST && rdis_q == `CCRC_RDIS_RST && rth_q == `CCRC_RTH_RST);
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  property p_rst_out;
    @(posedge i_clk) $rose(i_rst_n) |->
      (o_fast_charge_ma == `CCRC_FCC_RST_MA && o_trickle_weak_ma == `CCRC_TWC_MA2 &&
       o_recharge_threshold_mv == `CCRC_RTH_MV3 && o_rd_data == 8'h00);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong");
endmodule

// ---- verification/ccrc_host.sv ----
// Host model issuing register writes and address selects
`timescale 1ns/1ps
module ccrc_host (
  // Clock
  input  wire logic i_clk,
  // Register access
  output logic [7:0] o_addr,
  output logic       o_wr_en,
  output logic [7:0] o_wr_data
);
  initial begin
    o_addr = 8'h00;
    o_wr_en = 1'b0;
    o_wr_data = 8'h00;
  end
  // Held across one rising edge; address stays for read-back
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic en);
    @(negedge i_clk);
    o_addr = a;
    o_wr_data = d;
    o_wr_en = en;
    @(negedge i_clk);
    o_wr_en = 1'b0;
  endtask
endmodule

// ---- verification/ccrc_regs_bench.sv ----
// Bench for the charge current and recharge configuration registers
`timescale 1ns/1ps
module ccrc_regs_bench;
  import ccrc_pkg::*;
  logic        i_clk, i_rst_n, wen, dis, ren;
  logic [7:0]  addr, wdat;
  ccrc_byte_t  rd;
  logic [4:0]  fcc;
  logic [1:0]  twc, rth;
  logic [10:0] fma;
  logic [6:0]  tma;
  logic [8:0]  mv;
  int          mismatches, cmp_count, cycles;
  logic [34:0] rows [9] = '{{8'h04, 8'h5b, 8'h5b, 11'h4b0}, {8'h04, 8'hdc, 8'h5c, 11'h514},
    {8'h04, 8'h01, 8'h01, 11'h032}, {8'h04, 8'h56, 8'h56, 11'h44c}, {8'h04, 8'h7f, 8'h7f, 11'h514},
    {8'h05, 8'h9f, 8'h80, 11'h050}, {8'h05, 8'h20, 8'h20, 11'h08c}, {8'h05, 8'h40, 8'h40, 11'h0c8},
    {8'h05, 8'h60, 8'h60, 11'h104}};
  logic [6:0]  tm [4] = '{7'h05, 7'h0a, 7'h14, 7'h50};
  ccrc_host host_u (.i_clk(i_clk), .o_addr(addr), .o_wr_en(wen), .o_wr_data(wdat));
  ccrc_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wr_en(wen), .i_wr_data(wdat),
    .o_rd_data(rd), .o_fast_charge_current_code(fcc), .o_trickle_weak_current_code(twc),
    .o_recharge_disable(dis), .o_recharge_threshold_code(rth), .o_fast_charge_ma(fma),
    .o_trickle_weak_ma(tma), .o_recharge_threshold_mv(mv), .o_recharge_enable(ren));
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkdef;
    chk("codes", {5'h0e, 2'h2, 1'h0, 2'h3, 1'h1}, {fcc, twc, dis, rth, ren});
    chk("fma", 11'h2ee, fma);
    chk("tma", {4'h0, 7'h14}, {4'h0, tma});
    chk("mv", {2'h0, 9'h104}, {2'h0, mv});
    chk("rd", 11'h000, {3'h0, rd});
  endtask
  task test_done;
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 400) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    chkdef();
    i_rst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      host_u.wr(rows[i][34:27], rows[i][26:19], 1'b1);
      chk("rd", {3'h0, rows[i][18:11]}, {3'h0, rd});
      chk("set", rows[i][10:0], (rows[i][34:27] == 8'h04) ? fma : {2'h0, mv});
    end
    for (int t = 0; t < 4; t++) begin
      host_u.wr(8'h04, {1'b0, 5'h0e, 2'(t)}, 1'b1);
      chk("tma", {4'h0, tm[t]}, {4'h0, tma});
    end
    host_u.wr(8'h05, 8'h80, 1'b1);
    chk("rdis", {9'h0, 2'h2}, {9'h0, dis, ren});
    host_u.wr(8'h06, 8'hff, 1'b1);
    chk("unmap", {3'h0, 8'h00}, {3'h0, rd});
    chk("keep", 11'h2ee, fma);
    chk("keep", {9'h0, 2'h2}, {9'h0, dis, ren});
    host_u.wr(8'h04, 8'h00, 1'b0);
    chk("rdbk", {3'h0, 8'h3b}, {3'h0, rd});
    host_u.wr(8'h00, 8'h00, 1'b0);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    chkdef();
    i_rst_n = 1'b1;
    @(negedge i_clk);
    chkdef();
    host_u.wr(8'h04, 8'h5b, 1'b1);
    chk("rst1", {3'h0, 8'h5b}, {3'h0, rd});
    chk("rst1", 11'h4b0, fma);
    test_done();
  end
endmodule
